// ### design/mbs_regmap.sv
`timescale 1ns/1ps
`default_nettype none
`include "mbs_map.svh"

module mbs_regmap
	import mbs_pkg::*;
#(
	parameter int          MS_CYCLES      = `MBS_MS_CYCLES,
	parameter logic [63:0] ORDER_CODE     = 64'h0000_0000_0000_0001, // arbitrary value
	parameter logic [15:0] FW_LEVEL       = 16'h0001,                // arbitrary value
	parameter logic [15:0] HW_VERSION     = 16'h0001,                // arbitrary value
	parameter logic [15:0] LOADER_VERSION = 16'h0001,                // arbitrary value
	parameter logic [15:0] LAYOUT_VERSION = 16'h0001                 // arbitrary value
) (
	input  wire logic        clk,          // system clock
	input  wire logic        srst,         // sync reset, active high
	input  wire logic        req,          // one-word access request
	input  wire logic        we,           // 1 = write, 0 = read
	input  wire logic [15:0] addr,         // word address
	input  wire logic [15:0] wdata,        // write data
	output logic             ack,          // answer pulse
	output logic [15:0]      rdata,        // read data
	output mbs_exc_t         exc,          // exception code, 0 = none
	output logic             img_req,      // image access strobe
	output logic             img_we,       // image write strobe
	output logic [15:0]      img_addr,     // image word address
	output logic [15:0]      img_wdata,    // image write data
	input  wire logic [15:0] img_rdata,    // image read data, same cycle
	input  wire logic [15:0] led_code_1,   // io_status_led code part 1
	input  wire logic [15:0] led_code_2,   // io_status_led code part 2
	input  wire logic [15:0] led_code_3,   // io_status_led code part 3
	input  wire logic        prog_running, // controller program runs
	input  wire logic [47:0] mac_id,       // network identifier
	output mbs_wd_state_t    wd_state,     // watchdog state
	output logic             wd_expired    // watchdog expired level
);

	// ****************************************
	// storage
	// ****************************************
	logic [15:0]   wd_timeout;
	logic [15:0]   wd_config;
	logic [15:0]   tcp_wd;
	logic [15:0]   wd_left;
	logic [15:0]   live_cnt;
	logic          ms_tick;

	// ****************************************
	// decode results
	// ****************************************
	logic          in_img;
	logic          out_img;
	logic [15:0]   next_rdata;
	mbs_exc_t      next_exc;
	logic          tmo_we;
	logic          cfg_we;
	logic          tcp_we;
	logic          cmd_ok;
	mbs_wd_state_t cmd_state;
	logic          simple;
	logic          next_simple;

	assign simple      = wd_config[`MBS_CFG_SIMPLE_BIT];
	assign next_simple = wdata[`MBS_CFG_SIMPLE_BIT];

	// millisecond step source
	mbs_ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.clk (clk),
		.srst(srst),
		.tick(ms_tick)
	);

	// ****************************************
	// area split and image forwarding
	// ****************************************
	// three areas
	assign in_img    = (addr <= `MBS_IN_IMG_LAST);
	assign out_img   = (addr >= `MBS_OUT_IMG_FIRST) && (addr <= `MBS_OUT_IMG_LAST);
	assign img_req   = req && ((in_img && !we) || out_img);
	assign img_we    = req && we && out_img;
	assign img_addr  = addr;
	assign img_wdata = wdata;

	// ****************************************
	// access decode
	// ****************************************
	always_comb begin
		next_rdata = 16'h0000;
		next_exc   = MBS_EXC_NONE;
		tmo_we     = 1'b0;
		cfg_we     = 1'b0;
		tcp_we     = 1'b0;
		cmd_ok     = 1'b0;
		cmd_state  = wd_state;
		if (in_img) begin
			if (we) begin
				next_exc = MBS_EXC_ILL_ADDR;
			end else begin
				next_rdata = img_rdata;
			end
		end else if (out_img) begin
			next_rdata = img_rdata;
		end else if (addr == `MBS_WD_COMMAND) begin
			if (we) begin
				// watchdog command checks
				if (wdata == `MBS_CMD_START) begin
					if (wd_state == MBS_WD_UNCONF ||
					    (wd_state == MBS_WD_EXPIRED && !simple)) begin
						next_exc = MBS_EXC_ILL_DATA;
					end else begin
						cmd_ok    = 1'b1;
						cmd_state = MBS_WD_RUNNING;
					end
				end else if (wdata == `MBS_CMD_STOP) begin
					if (wd_state == MBS_WD_UNCONF || wd_state == MBS_WD_EXPIRED || simple) begin
						next_exc = MBS_EXC_ILL_DATA;
					end else begin
						cmd_ok    = 1'b1;
						cmd_state = MBS_WD_STOPPED;
					end
				end else if (wdata == `MBS_CMD_RESET) begin
					if (wd_state == MBS_WD_EXPIRED && !simple) begin
						cmd_ok    = 1'b1;
						cmd_state = MBS_WD_STOPPED;
					end else begin
						next_exc = MBS_EXC_ILL_DATA;
					end
				end else begin
					next_exc = MBS_EXC_ILL_DATA;
				end
			end else begin
				next_rdata = 16'h0000;
			end
		end else if (addr == `MBS_WD_TIMEOUT) begin
			if (we) begin
				if (wd_state == MBS_WD_RUNNING || wd_state == MBS_WD_EXPIRED) begin
					next_exc = MBS_EXC_ILL_FUNC;
				end else begin
					tmo_we = 1'b1;
				end
			end else begin
				next_rdata = wd_timeout;
			end
		end else if (addr == `MBS_WD_CONFIG) begin
			cfg_we     = we;
			next_rdata = wd_config;
		end else if (addr == `MBS_TCP_WATCHDOG) begin
			tcp_we     = we;
			next_rdata = tcp_wd;
		end else if (we) begin
			// every other special word is read-only or unassigned
			next_exc = MBS_EXC_ILL_ADDR;
		end else if (addr == `MBS_WD_STATE) begin
			next_rdata = {14'h0000, wd_state};
		end else if (addr == `MBS_LED_CODE_1) begin
			next_rdata = led_code_1;
		end else if (addr == `MBS_LED_CODE_2) begin
			next_rdata = led_code_2;
		end else if (addr == `MBS_LED_CODE_3) begin
			next_rdata = led_code_3;
		end else if (addr == `MBS_RUN_STATE) begin
			next_rdata = prog_running ? `MBS_VAL_RUNNING : `MBS_VAL_STOPPED;
		end else if (addr >= `MBS_ORDER_CODE && addr <= `MBS_ORDER_CODE_LAST) begin
			// most significant word first
			next_rdata = ORDER_CODE[63 - 16 * addr[1:0] -: 16];
		end else if (addr == `MBS_FW_LEVEL) begin
			next_rdata = FW_LEVEL;
		end else if (addr == `MBS_HW_VERSION) begin
			next_rdata = HW_VERSION;
		end else if (addr == `MBS_LOADER_VERSION) begin
			next_rdata = LOADER_VERSION;
		end else if (addr == `MBS_LAYOUT_VERSION) begin
			next_rdata = LAYOUT_VERSION;
		end else if (addr >= `MBS_MAC_ID && addr <= `MBS_MAC_ID_LAST) begin
			next_rdata = mac_id[47 - 16 * addr[1:0] -: 16];
		end else if (addr == `MBS_IN_CNT_TOTAL) begin
			next_rdata = `MBS_VAL_CNT_WORDS;
		end else if (addr == `MBS_IN_CNT_ANALOG) begin
			next_rdata = `MBS_VAL_CNT_WORDS;
		end else if (addr == `MBS_IN_CNT_DIGITAL) begin
			next_rdata = `MBS_VAL_CNT_BITS;
		end else if (addr == `MBS_OUT_CNT_TOTAL) begin
			next_rdata = `MBS_VAL_CNT_WORDS;
		end else if (addr == `MBS_OUT_CNT_ANALOG) begin
			next_rdata = `MBS_VAL_CNT_WORDS;
		end else if (addr == `MBS_OUT_CNT_DIGITAL) begin
			next_rdata = `MBS_VAL_CNT_BITS;
		end else if (addr == `MBS_TEST_A) begin
			next_rdata = `MBS_VAL_TEST_A;
		end else if (addr == `MBS_TEST_B) begin
			next_rdata = `MBS_VAL_TEST_B;
		end else if (addr == `MBS_TEST_C) begin
			next_rdata = `MBS_VAL_TEST_C;
		end else if (addr == `MBS_LIVE_WORD) begin
			next_rdata = live_cnt;
		end else begin
			next_exc = MBS_EXC_ILL_ADDR;
		end
	end

	// ****************************************
	// answer registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			ack   <= 1'b0;
			rdata <= 16'h0000;
			exc   <= MBS_EXC_NONE;
		end else begin
			ack <= req;
			if (req) begin
				rdata <= (next_exc == MBS_EXC_NONE) ? next_rdata : 16'h0000;
				exc   <= next_exc;
			end
		end
	end

	// ****************************************
	// writable special words
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			wd_timeout <= `MBS_RST_TIMEOUT;
			wd_config  <= `MBS_RST_CONFIG;
			tcp_wd     <= `MBS_RST_TCP_WD;
		end else if (req) begin
			if (tmo_we) begin
				wd_timeout <= wdata;
			end
			if (cfg_we) begin
				wd_config <= wdata;
			end
			if (tcp_we) begin
				tcp_wd <= wdata;
			end
		end
	end

	// ****************************************
	// watchdog state
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			wd_state <= MBS_WD_UNCONF;
		end else if (req && tmo_we) begin
			if (wdata == 16'h0000) begin
				wd_state <= MBS_WD_UNCONF;
			end else if (simple) begin
				wd_state <= MBS_WD_RUNNING;
			end else begin
				wd_state <= MBS_WD_STOPPED;
			end
		end else if (req && cfg_we && next_simple != simple) begin
			// mode switch with a timeout set: simple runs at once, advanced stops
			if (wd_timeout == 16'h0000) begin
				wd_state <= MBS_WD_UNCONF;
			end else if (next_simple) begin
				wd_state <= MBS_WD_RUNNING;
			end else begin
				wd_state <= MBS_WD_STOPPED;
			end
		end else if (req && cmd_ok) begin
			wd_state <= cmd_state;
		end else if (wd_state == MBS_WD_RUNNING && ms_tick && wd_left <= 16'h0001) begin
			wd_state <= MBS_WD_EXPIRED;
		end
	end

	// ****************************************
	// watchdog countdown, 1 ms steps
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			wd_left <= 16'h0000;
		end else if (req && next_exc == MBS_EXC_NONE) begin
			// any good request retriggers
			wd_left <= tmo_we ? wdata : wd_timeout;
		end else if (wd_state != MBS_WD_RUNNING) begin
			wd_left <= wd_timeout;
		end else if (ms_tick && wd_left != 16'h0000) begin
			wd_left <= wd_left - 16'h0001;
		end
	end

	assign wd_expired = (wd_state == MBS_WD_EXPIRED);

	// ****************************************
	// live word, counts milliseconds
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			live_cnt <= 16'h0000;
		end else if (ms_tick) begin
			live_cnt <= live_cnt + 16'h0001;
		end
	end

endmodule

`default_nettype wire

// ### design/mbs_map.svh
`ifndef MBS_MAP_SVH
`define MBS_MAP_SVH

// ****************************************
// word-register areas
// ****************************************
`define MBS_IN_IMG_LAST     16'h7CFF
`define MBS_OUT_IMG_FIRST   16'h7D00
`define MBS_OUT_IMG_LAST    16'hF9FF

// ****************************************
// special area offsets
// ****************************************
`define MBS_WD_COMMAND      16'hFA00
`define MBS_WD_TIMEOUT      16'hFA01
`define MBS_WD_STATE        16'hFA02
`define MBS_WD_CONFIG       16'hFA03
`define MBS_TCP_WATCHDOG    16'hFA04
`define MBS_LED_CODE_1      16'hFA0A
`define MBS_LED_CODE_2      16'hFA0B
`define MBS_LED_CODE_3      16'hFA0C
`define MBS_RUN_STATE       16'hFA0D
`define MBS_ORDER_CODE      16'hFA10
`define MBS_ORDER_CODE_LAST 16'hFA13
`define MBS_FW_LEVEL        16'hFA14
`define MBS_HW_VERSION      16'hFA15
`define MBS_LOADER_VERSION  16'hFA16
`define MBS_LAYOUT_VERSION  16'hFA17
`define MBS_MAC_ID          16'hFA20
`define MBS_MAC_ID_LAST     16'hFA22
`define MBS_IN_CNT_TOTAL    16'hFA40
`define MBS_IN_CNT_ANALOG   16'hFA41
`define MBS_IN_CNT_DIGITAL  16'hFA42
`define MBS_OUT_CNT_TOTAL   16'hFA43
`define MBS_OUT_CNT_ANALOG  16'hFA44
`define MBS_OUT_CNT_DIGITAL 16'hFA45
`define MBS_TEST_A          16'hFAA0
`define MBS_TEST_B          16'hFAA1
`define MBS_TEST_C          16'hFAA2
`define MBS_LIVE_WORD       16'hFAFA

// ****************************************
// fixed read values
// ****************************************
`define MBS_VAL_CNT_WORDS   16'h7D00
`define MBS_VAL_CNT_BITS    16'h8000
`define MBS_VAL_TEST_A      16'h1234
`define MBS_VAL_TEST_B      16'hAAAA
`define MBS_VAL_TEST_C      16'h5555
`define MBS_VAL_STOPPED     16'h0001
`define MBS_VAL_RUNNING     16'h0002

// ****************************************
// watchdog commands, config, resets
// ****************************************
`define MBS_CMD_START       16'h5555
`define MBS_CMD_STOP        16'h55AA
`define MBS_CMD_RESET       16'hAAAA
`define MBS_CFG_SIMPLE_BIT  7
`define MBS_RST_TIMEOUT     16'h0000
`define MBS_RST_CONFIG      16'h0000
`define MBS_RST_TCP_WD      16'h0000

// ****************************************
// timing
// ****************************************
`define MBS_CLK_PERIOD_NS   5
`define MBS_WD_STEP_NS      1000000
`define MBS_MS_CYCLES       (`MBS_WD_STEP_NS / `MBS_CLK_PERIOD_NS)

`endif

// ### design/mbs_pkg.sv
package mbs_pkg;

	// watchdog states
	typedef enum logic [1:0] {
		MBS_WD_UNCONF  = 2'b00,
		MBS_WD_STOPPED = 2'b01,
		MBS_WD_RUNNING = 2'b10,
		MBS_WD_EXPIRED = 2'b11
	} mbs_wd_state_t;

	// modbus exception answers
	typedef enum logic [7:0] {
		MBS_EXC_NONE     = 8'h00,
		MBS_EXC_ILL_FUNC = 8'h01,
		MBS_EXC_ILL_ADDR = 8'h02,
		MBS_EXC_ILL_DATA = 8'h03
	} mbs_exc_t;

endpackage

// ### design/mbs_ms_tick.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// millisecond step divider
// ****************************************
module mbs_ms_tick #(
	parameter int CYCLES = 200000
) (
	input  wire logic clk,   // system clock
	input  wire logic srst,  // sync reset
	output logic      tick   // one-cycle pulse per step
);

	localparam int CW = $clog2(CYCLES);

	logic [CW-1:0] cnt;

	// count up, pulse on wrap
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (cnt == CW'(CYCLES - 1)) begin
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + CW'(1);
			tick <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ### tb/mbs_img_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// image store model
// ****************
module mbs_img_model (
	input  wire logic        clk,       // system clock
	input  wire logic        img_req,   // image strobe
	input  wire logic        img_we,    // image write
	input  wire logic [15:0] img_addr,  // word address
	input  wire logic [15:0] img_wdata, // write data
	output logic [15:0]      img_rdata  // read data
);
	logic [15:0] mem [0:63];

	// known contents, 0x1000 plus index
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 16'h1000 + 16'(i);
		end
	end

	always @(posedge clk) begin
		if (img_req && img_we) begin
			mem[img_addr[5:0]] <= img_wdata;
		end
	end

	// idle bus shows no stale word
	assign img_rdata = img_req ? mem[img_addr[5:0]] : ~img_addr;
endmodule
`default_nettype wire

// ### tb/mbs_regmap_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// register map checker
// ****************
module mbs_regmap_monitor
	import mbs_pkg::*;
(
	input wire logic          clk,          // system clock
	input wire logic          srst,         // sync reset
	input wire logic          req,          // request
	input wire logic          we,           // write
	input wire logic [15:0]   addr,         // address
	input wire logic [15:0]   wdata,        // write data
	input wire logic          ack,          // answer
	input wire logic [15:0]   rdata,        // read data
	input wire mbs_exc_t      exc,          // exception
	input wire logic          img_req,      // image strobe
	input wire logic          img_we,       // image write
	input wire logic [15:0]   led_code_2,   // led part 2
	input wire logic          prog_running, // program runs
	input wire mbs_wd_state_t wd_state      // watchdog state
);
	logic rd;

	// read request
	assign rd = req & ~we;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_ack_timing: assert property (req |=> ack)
		else $error("no answer after request");
	a_ack_cause: assert property (ack |-> $past(req))
		else $error("answer without request");
	a_img_strobe: assert property (img_req == (req && (addr inside {[16'h7D00:16'hF9FF]} || !we && addr <= 16'h7CFF)))
		else $error("image strobe wrong");
	a_img_write: assert property (img_we == (req && we && addr inside {[16'h7D00:16'hF9FF]}))
		else $error("image write strobe wrong");
	a_run_word: assert property (rd && addr == 16'hFA0D |=> rdata == ($past(prog_running) ? 16'h0002 : 16'h0001))
		else $error("run state word wrong");
	a_led_word: assert property (rd && addr == 16'hFA0B |=> rdata == $past(led_code_2))
		else $error("led code word wrong");
	a_analog_count: assert property (rd && addr == 16'hFA41 |=> rdata == 16'h7D00 && exc == MBS_EXC_NONE)
		else $error("analog count wrong");
	a_digital_count: assert property (rd && addr inside {16'hFA42, 16'hFA45} |=> rdata == 16'h8000)
		else $error("digital count wrong");
	a_cmd_hidden: assert property (rd && addr == 16'hFA00 |=> rdata == 16'h0000)
		else $error("command word readable");
	a_start_unconf: assert property (req && we && addr == 16'hFA00 && wd_state == MBS_WD_UNCONF
		|=> exc == MBS_EXC_ILL_DATA && wd_state == MBS_WD_UNCONF)
		else $error("command accepted unconfigured");
	a_zero_timeout: assert property (req && we && addr == 16'hFA01 && wdata == 16'h0000
		&& wd_state == MBS_WD_UNCONF |=> wd_state == MBS_WD_UNCONF)
		else $error("zero timeout configured");
	a_ro_refused: assert property (req && (we && addr <= 16'h7CFF || addr inside {[16'hFA05:16'hFA09]}
		|| we && addr inside {[16'hFA0A:16'hFA0D], [16'hFA40:16'hFA45]}) |=> exc == MBS_EXC_ILL_ADDR)
		else $error("refusal missing");
endmodule

bind mbs_regmap mbs_regmap_monitor mon (.clk, .srst, .req, .we, .addr, .wdata, .ack, .rdata, .exc,
	.img_req, .img_we, .led_code_2, .prog_running, .wd_state);
`default_nettype wire

// ### tb/modbus_slave_register_map_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// register map bench
// ****************
module modbus_slave_register_map_test
	import mbs_pkg::*;
;
	localparam logic [15:0] LAYOUT = 16'h0203; // arbitrary value
	localparam logic [47:0] MAC    = 48'h0A1B_2C3D_4E5F;
	localparam logic [15:0] FA [10] = '{16'hFA40, 16'hFA41, 16'hFA42, 16'hFA43, 16'hFA44,
		16'hFA45, 16'hFAA0, 16'hFAA1, 16'hFAA2, 16'hFA17};
	localparam logic [15:0] FV [10] = '{16'h7D00, 16'h7D00, 16'h8000, 16'h7D00, 16'h7D00,
		16'h8000, 16'h1234, 16'hAAAA, 16'h5555, LAYOUT};
	localparam logic [15:0] UA [5] = '{16'hFA05, 16'hFA0E, 16'hFA18, 16'hFAFB, 16'hFFFF};
	logic          clk, srst, req, we, ack, img_req, img_we, prog_running, wd_expired;
	logic [15:0]   addr, wdata, rdata, img_addr, img_wdata, img_rdata, led1, led2, led3, got;
	mbs_exc_t      exc, gotx;
	mbs_wd_state_t wd_state;
	int            failures, checks_done;

	mbs_regmap #(.MS_CYCLES(10), .LAYOUT_VERSION(LAYOUT)) dut (.clk(clk), .srst(srst), .req(req),
		.we(we), .addr(addr), .wdata(wdata), .ack(ack), .rdata(rdata), .exc(exc), .img_req(img_req),
		.img_we(img_we), .img_addr(img_addr), .img_wdata(img_wdata), .img_rdata(img_rdata),
		.led_code_1(led1), .led_code_2(led2), .led_code_3(led3), .prog_running(prog_running),
		.mac_id(MAC), .wd_state(wd_state), .wd_expired(wd_expired));
	mbs_img_model partner (.clk(clk), .img_req(img_req), .img_we(img_we), .img_addr(img_addr),
		.img_wdata(img_wdata), .img_rdata(img_rdata));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic cmp_word(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp_exc(input mbs_exc_t g, input mbs_exc_t e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one word access, answer taken a cycle later
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		req = 1'b1;
		we = w;
		addr = a;
		wdata = d;
		@(negedge clk);
		req = 1'b0;
		cmp_word({15'h0000, ack}, 16'h0001);
		got = rdata;
		gotx = exc;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		access(1'b0, a, 16'h0000);
		cmp_word(got, e);
		cmp_exc(gotx, MBS_EXC_NONE);
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input mbs_exc_t e);
		access(1'b1, a, d);
		cmp_exc(gotx, e);
	endtask

	task automatic print_verdict;
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		#20000;
		failures++;
		print_verdict();
	end

	// main sequence
	initial begin
		srst = 1'b1;
		req = 1'b0;
		we = 1'b0;
		addr = 16'h0000;
		wdata = 16'h0000;
		prog_running = 1'b0;
		led1 = 16'h0101;
		led2 = 16'h0202;
		led3 = 16'h0303;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		rd(16'hFA00, 16'h0000);
		rd(16'hFA01, 16'h0000);
		wr(16'hFA00, 16'h5555, MBS_EXC_ILL_DATA);
		wr(16'hFA01, 16'h0000, MBS_EXC_NONE);
		rd(16'hFA02, 16'h0000);
		for (int i = 0; i < 10; i++) begin
			rd(FA[i], FV[i]);
		end
		rd(16'hFA0A, 16'h0101);
		rd(16'hFA0C, 16'h0303);
		led2 = 16'h2222;
		rd(16'hFA0B, 16'h2222);
		rd(16'hFA0D, 16'h0001);
		prog_running = 1'b1;
		rd(16'hFA0D, 16'h0002);
		rd(16'hFA20, MAC[47:32]);
		rd(16'hFA22, MAC[15:0]);
		rd(16'h0005, 16'h1005);
		wr(16'h0005, 16'hBEEF, MBS_EXC_ILL_ADDR);
		rd(16'h0005, 16'h1005);
		wr(16'h7D00, 16'hBEEF, MBS_EXC_NONE);
		rd(16'h7D00, 16'hBEEF);
		rd(16'hF9FF, 16'h103F);
		wr(16'hFA0D, 16'h0001, MBS_EXC_ILL_ADDR);
		wr(16'hFA42, 16'h0000, MBS_EXC_ILL_ADDR);
		for (int i = 0; i < 5; i++) begin
			access(1'b0, UA[i], 16'h0000);
			cmp_exc(gotx, MBS_EXC_ILL_ADDR);
		end
		wr(16'hFA01, 16'h0003, MBS_EXC_NONE);
		rd(16'hFA02, 16'h0001);
		wr(16'hFA00, 16'h5555, MBS_EXC_NONE);
		rd(16'hFA00, 16'h0000);
		rd(16'hFA02, 16'h0002);
		wr(16'hFA01, 16'h0005, MBS_EXC_ILL_FUNC);
		repeat (60) @(negedge clk);
		cmp_word({15'h0000, wd_expired}, 16'h0001);
		cmp_word({14'h0000, wd_state}, 16'h0003);
		wr(16'hFA00, 16'hAAAA, MBS_EXC_NONE);
		rd(16'hFA02, 16'h0001);
		// stop and unknown commands, tcp word
		wr(16'hFA00, 16'h55AA, MBS_EXC_NONE);
		wr(16'hFA00, 16'h1234, MBS_EXC_ILL_DATA);
		wr(16'hFA04, 16'h0042, MBS_EXC_NONE);
		rd(16'hFA04, 16'h0042);
		// simple mode: runs at once, stop refused, restart after expiry
		wr(16'hFA03, 16'h0080, MBS_EXC_NONE);
		rd(16'hFA03, 16'h0080);
		rd(16'hFA02, 16'h0002);
		wr(16'hFA00, 16'h55AA, MBS_EXC_ILL_DATA);
		repeat (60) @(negedge clk);
		cmp_word({14'h0000, wd_state}, 16'h0003);
		wr(16'hFA00, 16'h5555, MBS_EXC_NONE);
		rd(16'hFA02, 16'h0002);
		wr(16'hFA03, 16'h0000, MBS_EXC_NONE);
		rd(16'hFA02, 16'h0001);
		// mid-run reset clears the writable words
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		rd(16'hFA01, 16'h0000);
		rd(16'hFA02, 16'h0000);
		rd(16'hFA03, 16'h0000);
		rd(16'hFA04, 16'h0000);
		wr(16'hFA00, 16'h5555, MBS_EXC_ILL_DATA);
		print_verdict();
	end
endmodule
`default_nettype wire
